// [hdl/motor_ctrl_defines.vh]
// Overview of operation
// - Start mode selects search or normal start
// - Unassigned start select reads as on
// - Search code 999 starts at maximum frequency
// - Mode sets first search direction
// - Opposite direction tried only after failure
// - Stop shifting once motor is synchronised
// - Seven failed retries raise alarm, stop
// - Stop mode 0 ramps down to standstill
// - Stop mode 1 shuts output at once
// - Low reference frequency always ramps down
// - Limit setting chooses trip or limiting
// - Limiting gates off output, keeps regulating
// - Thermistor mode 1 trips to alarm stop
// - Thermistor mode 2 alarms, keeps running
// - Compare divided thermistor voltage to level
`ifndef MOTOR_CTRL_DEFINES_VH
`define MOTOR_CTRL_DEFINES_VH
`define ADDR_CTRL       12'h000
`define ADDR_SEARCH     12'h004
`define ADDR_LEVELS     12'h008
`define ADDR_STATUS     12'h00C
`define ADDR_IRQ_STAT   12'h010
`define ADDR_IRQ_MASK   12'h014
`define SEARCH_MAX_CODE 16'h03E7
`define MAX_RETRIES     3'h7
`define TRIAL_LIMIT     16'hFFFF
`define ST_IDLE         3'h0
`define ST_SEARCH       3'h1
`define ST_RUN          3'h2
`define ST_DECEL        3'h3
`define ST_ALARM        3'h4
`define MODE_DISABLE    3'h0
`define MODE_SEARCH_A   3'h3
`define MODE_SEARCH_B   3'h4
`define MODE_SEARCH_C   3'h5
`define THM_OFF         2'h0
`define THM_TRIP        2'h1
`define THM_WARN        2'h2
`define EV_SEARCH_FAIL  0
`define EV_OC_TRIP      1
`define EV_THM_TRIP     2
`define EV_THM_WARN     3
`define EV_SYNC         4
`define EV_WIDTH        5
`endif

// [hdl/motor_start_stop_protection_ctrl.v]
`timescale 1ns/1ps
`include "motor_ctrl_defines.vh"
module motor_start_stop_protection_ctrl
(
   input  wire        clk,
   input  wire        rstn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        run_cmd,
   input  wire        run_reverse,
   input  wire        start_select_input,
   input  wire        start_select_assigned,
   input  wire        motor_synced,
   input  wire        overcurrent,
   input  wire        ref_freq_low,
   input  wire        decel_done,
   input  wire [9:0]  thermistor_level,
   output reg         gate_enable,
   output reg         search_active,
   output reg         search_reverse,
   output reg  [15:0] start_freq,
   output reg         ramp_decel,
   output reg         current_limiting,
   output reg         motor_overheat_output,
   output reg         irq
);
// Pin inputs pass two flip-flops
reg  [7:0] sync1;
reg  [7:0] sync2;
reg  [9:0] lvl1;
reg  [9:0] lvl2;
wire       run_s     = sync2[0];
wire       rev_s     = sync2[1];
wire       stm_s     = sync2[2];
wire       stm_asg_s = sync2[3];
wire       synced_s  = sync2[4];
wire       oc_s      = sync2[5];
wire       low_s     = sync2[6];
wire       ddone_s   = sync2[7];
always @(posedge clk)
begin
   if (!rstn)
   begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
      lvl1  <= 10'h000;
      lvl2  <= 10'h000;
   end
   else
   begin
      sync1 <= {decel_done, ref_freq_low, overcurrent, motor_synced,
                start_select_assigned, start_select_input, run_reverse,
                run_cmd};
      sync2 <= sync1;
      lvl1  <= thermistor_level;
      lvl2  <= lvl1;
   end
end
// --------------------------------------------------------------
// Registers
// --------------------------------------------------------------
reg  [2:0]           start_search_mode_setting;
reg                  stop_mode_setting;
reg                  instant_current_limit_setting;
reg  [1:0]           thermistor_mode_setting;
reg  [1:0]           ramp_pattern_setting;
reg  [15:0]          search_start_frequency;
reg  [15:0]          max_frequency;
reg  [9:0]           thermistor_detect_level;
reg  [15:0]          decel_time_setting;
reg  [`EV_WIDTH-1:0] irq_stat;
reg  [`EV_WIDTH-1:0] irq_mask;
reg  [`EV_WIDTH-1:0] events;
reg  [2:0]           state;
reg  [2:0]           retries;
reg                  second_trial;
reg  [15:0]          trial_cnt;
reg                  run_d;
wire wr = psel && penable && pwrite && pready;
function [2:0] fail_code;
   input [2:0] st;
   begin
      fail_code = st;
   end
endfunction
// Start select counts as on when no terminal carries it
wire stm_eff = stm_s || !stm_asg_s;
wire search_mode = (start_search_mode_setting == `MODE_SEARCH_A) ||
                   (start_search_mode_setting == `MODE_SEARCH_B) ||
                   (start_search_mode_setting == `MODE_SEARCH_C);
wire do_search = search_mode && stm_eff;
// Mode 5 begins opposite to the run direction
wire first_rev = (start_search_mode_setting == `MODE_SEARCH_C) ?
                 !rev_s : rev_s;
// Divided thermistor voltage against level, 0.00 to 5.00 V scale
wire thm_over = lvl2 > thermistor_detect_level;
wire run_rise = run_s && !run_d;
wire trial_end = (trial_cnt == `TRIAL_LIMIT);
// --------------------------------------------------------------
// APB slave
// --------------------------------------------------------------
always @(posedge clk)
begin
   if (!rstn)
   begin
      pready                        <= 1'b0;
      pslverr                       <= 1'b0;
      prdata                        <= 32'h0000_0000;
      start_search_mode_setting     <= `MODE_DISABLE;
      stop_mode_setting             <= 1'b0;
      instant_current_limit_setting <= 1'b0;
      thermistor_mode_setting       <= `THM_OFF;
      ramp_pattern_setting          <= 2'b00;
      search_start_frequency        <= 16'h0000;
      max_frequency                 <= 16'h0000;
      thermistor_detect_level       <= 10'h000;
      decel_time_setting            <= 16'h0000;
      irq_mask                      <= {`EV_WIDTH{1'b0}};
      irq_stat                      <= {`EV_WIDTH{1'b0}};
   end
   else
   begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable)
      begin
         prdata <= 32'h0000_0000;
         if (paddr == `ADDR_CTRL)
            prdata <= {23'h00_0000,
                       ramp_pattern_setting, thermistor_mode_setting,
                       instant_current_limit_setting, stop_mode_setting,
                       start_search_mode_setting};
         else if (paddr == `ADDR_SEARCH)
            prdata <= {max_frequency, search_start_frequency};
         else if (paddr == `ADDR_LEVELS)
            prdata <= {decel_time_setting, 6'h00, thermistor_detect_level};
         else if (paddr == `ADDR_STATUS)
            prdata <= {16'h0000, lvl2, state, retries};
         else if (paddr == `ADDR_IRQ_STAT)
            prdata <= {27'h0000_000, irq_stat};
         else if (paddr == `ADDR_IRQ_MASK)
            prdata <= {27'h0000_000, irq_mask};
         else
            pslverr <= 1'b1;
      end
      if (wr)
      begin
         if (paddr == `ADDR_CTRL)
         begin
            start_search_mode_setting     <= pwdata[2:0];
            stop_mode_setting             <= pwdata[3];
            instant_current_limit_setting <= pwdata[4];
            thermistor_mode_setting       <= pwdata[6:5];
            ramp_pattern_setting          <= pwdata[8:7];
         end
         else if (paddr == `ADDR_SEARCH)
         begin
            search_start_frequency <= pwdata[15:0];
            max_frequency          <= pwdata[31:16];
         end
         else if (paddr == `ADDR_LEVELS)
         begin
            thermistor_detect_level <= pwdata[9:0];
            decel_time_setting      <= pwdata[31:16];
         end
         else if (paddr == `ADDR_IRQ_MASK)
            irq_mask <= pwdata[`EV_WIDTH-1:0];
      end
      // Set wins over write-one-to-clear
      if (wr && paddr == `ADDR_IRQ_STAT)
         irq_stat <= (irq_stat & ~pwdata[`EV_WIDTH-1:0]) | events;
      else
         irq_stat <= irq_stat | events;
   end
end
// --------------------------------------------------------------
// Start, search, stop and protection sequencer
// --------------------------------------------------------------
always @(posedge clk)
begin
   if (!rstn)
   begin
      state                 <= `ST_IDLE;
      retries               <= 3'h0;
      second_trial          <= 1'b0;
      trial_cnt             <= 16'h0000;
      run_d                 <= 1'b0;
      events                <= {`EV_WIDTH{1'b0}};
      gate_enable           <= 1'b0;
      search_active         <= 1'b0;
      search_reverse        <= 1'b0;
      start_freq            <= 16'h0000;
      ramp_decel            <= 1'b0;
      current_limiting      <= 1'b0;
      motor_overheat_output <= 1'b0;
      irq                   <= 1'b0;
   end
   else
   begin
      run_d  <= run_s;
      events <= {`EV_WIDTH{1'b0}};
      irq    <= |(irq_stat & irq_mask);
      current_limiting <= 1'b0;
      motor_overheat_output <= (thermistor_mode_setting == `THM_WARN) &&
                               thm_over;
      if (thermistor_mode_setting == `THM_WARN && thm_over)
         events[`EV_THM_WARN] <= 1'b1;
      case (state)
      `ST_IDLE:
      begin
         gate_enable <= 1'b0;
         ramp_decel  <= 1'b0;
         if (run_rise)
         begin
            retries      <= 3'h0;
            second_trial <= 1'b0;
            trial_cnt    <= 16'h0000;
            gate_enable  <= 1'b1;
            if (do_search)
            begin
               state          <= `ST_SEARCH;
               search_active  <= 1'b1;
               search_reverse <= first_rev;
               start_freq     <= (search_start_frequency ==
                                  `SEARCH_MAX_CODE) ? max_frequency
                                 : search_start_frequency;
            end
            else
            begin
               state      <= `ST_RUN;
               start_freq <= 16'h0000;
            end
         end
      end
      `ST_SEARCH:
      begin
         trial_cnt <= trial_cnt + 16'h0001;
         if (synced_s)
         begin
            state         <= `ST_RUN;
            search_active <= 1'b0;
            retries       <= 3'h0;
            events[`EV_SYNC] <= 1'b1;
         end
         else if (trial_end)
         begin
            trial_cnt <= 16'h0000;
            if (start_search_mode_setting == `MODE_SEARCH_C &&
                !second_trial)
            begin
               second_trial   <= 1'b1;
               search_reverse <= !search_reverse;
            end
            else if (retries == fail_code(`MAX_RETRIES))
            begin
               state         <= `ST_ALARM;
               search_active <= 1'b0;
               gate_enable   <= 1'b0;
               events[`EV_SEARCH_FAIL] <= 1'b1;
            end
            else
            begin
               retries        <= retries + 3'h1;
               second_trial   <= 1'b0;
               search_reverse <= first_rev;
            end
         end
      end
      `ST_RUN:
      begin
         if (!run_s)
         begin
            search_active <= 1'b0;
            if (stop_mode_setting && !low_s)
            begin
               state       <= `ST_IDLE;
               gate_enable <= 1'b0;
            end
            else
            begin
               state      <= `ST_DECEL;
               ramp_decel <= 1'b1;
            end
         end
      end
      `ST_DECEL:
      begin
         if (ddone_s)
         begin
            state       <= `ST_IDLE;
            ramp_decel  <= 1'b0;
            gate_enable <= 1'b0;
         end
      end
      default:
      begin
         gate_enable   <= 1'b0;
         search_active <= 1'b0;
         ramp_decel    <= 1'b0;
         if (!run_s && wr && paddr == `ADDR_STATUS)
            state <= `ST_IDLE;
      end
      endcase
      // Protection overrides the sequence
      if (state != `ST_IDLE && state != `ST_ALARM && oc_s)
      begin
         if (instant_current_limit_setting)
         begin
            current_limiting <= 1'b1;
            gate_enable      <= 1'b0;
            if (state == `ST_SEARCH || state == `ST_RUN)
               gate_enable <= 1'b0;
         end
         else
         begin
            state       <= `ST_ALARM;
            gate_enable <= 1'b0;
            events[`EV_OC_TRIP] <= 1'b1;
         end
      end
      else if (state != `ST_IDLE && state != `ST_ALARM && oc_s == 1'b0 &&
               current_limiting)
         gate_enable <= 1'b1;
      if (thermistor_mode_setting == `THM_TRIP && thm_over &&
          state != `ST_ALARM)
      begin
         state       <= `ST_ALARM;
         gate_enable <= 1'b0;
         events[`EV_THM_TRIP] <= 1'b1;
      end
   end
end
endmodule

// [tb/motor_ctrl_checker.sv]
`timescale 1ns/1ps
module motor_ctrl_checker
(
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        motor_synced,
   input wire logic        gate_enable,
   input wire logic        search_active,
   input wire logic [15:0] start_freq,
   input wire logic        ramp_decel,
   input wire logic        current_limiting,
   input wire logic        irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence answer_s;
      pready ##1 !pready;
   endsequence
   chk_apb_answer: assert property (setup_s |=> answer_s)
      else $error("no single ready pulse after setup");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("error flag without ready");
   chk_reset_quiet: assert property (disable iff (1'b0)
      !rstn |=> !gate_enable && !irq && !search_active)
      else $error("outputs active after reset");
   chk_sync_ends: assert property (
      search_active && motor_synced |-> ##[1:4] !search_active)
      else $error("search kept shifting after sync");
   chk_limit_gate: assert property (
      current_limiting |-> ##[0:1] !gate_enable)
      else $error("gates on while limiting");
   chk_ramp_gate: assert property (ramp_decel |-> gate_enable)
      else $error("ramp without output");
   chk_search_ramp: assert property (search_active |-> !ramp_decel)
      else $error("search and ramp together");
   chk_search_freq: assert property (
      $rose(search_active) |-> start_freq != 16'h0000)
      else $error("search began at normal frequency");
endmodule
bind motor_start_stop_protection_ctrl motor_ctrl_checker mon (.clk, .rstn,
   .psel, .penable, .pready, .pslverr, .motor_synced, .gate_enable,
   .search_active, .start_freq, .ramp_decel, .current_limiting, .irq);

// [tb/motor_model.sv]
`timescale 1ns/1ps
module motor_model
(
   input  wire logic clk,
   input  wire logic gate_enable,
   input  wire logic search_active,
   input  wire logic ramp_decel,
   input  wire logic oc_req,
   output wire logic motor_synced,
   output wire logic decel_done,
   output wire logic overcurrent
);
   logic [4:0] sc = 5'h00;
   logic [4:0] dc = 5'h00;
   // Motor locks on after some search time, stops after some ramp time
   always @(posedge clk)
   begin
      sc <= search_active ? sc + {4'h0, !sc[4]} : 5'h00;
      dc <= ramp_decel ? dc + {4'h0, !dc[4]} : 5'h00;
   end
   assign motor_synced = sc[4];
   assign decel_done = dc[4];
   // Current flows only while the output gates conduct
   assign overcurrent = oc_req & gate_enable;
endmodule

// [tb/motor_start_stop_protection_ctrl_test.sv]
`timescale 1ns/1ps
`include "motor_ctrl_defines.vh"
module motor_start_stop_protection_ctrl_test;
   logic        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
   logic        run_cmd = 0, run_reverse = 0, ref_freq_low = 0, oc_req = 0;
   logic        start_select_input = 0, start_select_assigned = 0, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, rd;
   logic [9:0]  thermistor_level = 10'h000;
   logic [6:0]  row;
   logic [6:0]  rows [7] = '{7'h0C, 7'h3D, 7'h34, 7'h33, 7'h4F, 7'h5D, 7'h5F};
   wire  [31:0] prdata;
   wire  [15:0] start_freq;
   wire         pready, pslverr, motor_synced, overcurrent, decel_done;
   wire         gate_enable, search_active, search_reverse, ramp_decel;
   wire         current_limiting, motor_overheat_output, irq;
   wire  [5:0]  obs = {current_limiting, motor_overheat_output, irq,
                       ramp_decel, search_active, gate_enable};
   int          mismatches = 0, n_compared = 0, r, n;
   motor_start_stop_protection_ctrl uut (.clk, .rstn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .run_cmd,
      .run_reverse, .start_select_input, .start_select_assigned,
      .motor_synced, .overcurrent, .ref_freq_low, .decel_done,
      .thermistor_level, .gate_enable, .search_active, .search_reverse,
      .start_freq, .ramp_decel, .current_limiting, .motor_overheat_output,
      .irq);
   motor_model far (.clk, .gate_enable, .search_active, .ramp_decel,
      .oc_req, .motor_synced, .decel_done, .overcurrent);
   always #12.5 clk = ~clk;
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e)
      begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", nm, e, s);
      end
   endtask
   task close_out;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int j;
      @(posedge clk);
      psel   <= 1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      for (j = 0; j < 20 && pready !== 1'b1; j++)
         @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      chk("pready", j < 20, 1);
      if (j == 20)
         close_out;
   endtask
   task waitv(input int k, input logic v);
      for (n = 0; n < 1000 && obs[k] !== v; n++)
         @(posedge clk);
      chk("wait", n < 1000, 1);
      if (n == 1000)
         close_out;
   endtask
   task clr;
      run_cmd <= 0;
      oc_req <= 0;
      repeat (4) @(posedge clk);
      apb(1, `ADDR_STATUS, 0);
      apb(1, `ADDR_IRQ_STAT, 32'h0000_001F);
   endtask
   // ---------------------------------------------------------------
   // Sequence
   // ---------------------------------------------------------------
   initial
   begin
      repeat (3) @(posedge clk);
      rstn <= 1;
      chk("outputs", obs, 0);
      apb(1, `ADDR_SEARCH, 32'h1770_0123);
      apb(1, `ADDR_LEVELS, 32'h0010_0200);
      apb(0, 12'h0FC, 0);
      chk("pslverr", err, 1);
      $display("test reset end");
      for (r = 0; r < 7; r++)
      begin
         row = rows[r];
         apb(1, `ADDR_CTRL, {29'h0000_0002, row[6:4]});
         start_select_input <= row[3];
         start_select_assigned <= row[2];
         run_reverse <= row[1];
         run_cmd <= 1;
         waitv(0, 1);
         chk("search", search_active, row[0]);
         chk("freq", start_freq, row[0] ? 16'h0123 : 16'h0000);
         if (row[0])
            chk("dir", search_reverse, row[1] ^ (row[6:4] == 3'h5));
         waitv(1, 0);
         run_cmd <= 0;
         waitv(2, 1);
         waitv(0, 0);
         $display("test row %0d end", r);
      end
      apb(1, `ADDR_SEARCH, 32'h1770_03E7);
      apb(1, `ADDR_CTRL, 32'h0000_0013);
      run_cmd <= 1;
      waitv(0, 1);
      chk("max freq", start_freq, 16'h1770);
      waitv(1, 0);
      apb(0, `ADDR_IRQ_STAT, 0);
      chk("sync event", rd[4], 1);
      run_cmd <= 0;
      waitv(0, 0);
      apb(1, `ADDR_CTRL, 32'h0000_0018);
      for (r = 0; r < 2; r++)
      begin
         ref_freq_low <= r[0];
         run_cmd <= 1;
         waitv(0, 1);
         run_cmd <= 0;
         if (r == 1)
            waitv(2, 1);
         waitv(0, 0);
         if (r == 0)
            chk("coast", n < 8, 1);
      end
      ref_freq_low <= 0;
      $display("test stop end");
      apb(1, `ADDR_CTRL, 32'h0000_0000);
      clr;
      run_cmd <= 1;
      waitv(0, 1);
      oc_req <= 1;
      waitv(0, 0);
      apb(0, `ADDR_IRQ_STAT, 0);
      chk("oc trip", rd[1], 1);
      apb(1, `ADDR_IRQ_MASK, 32'h0000_001F);
      waitv(3, 1);
      apb(1, `ADDR_IRQ_MASK, 0);
      waitv(3, 0);
      clr;
      waitv(3, 0);
      apb(1, `ADDR_CTRL, 32'h0000_0010);
      run_cmd <= 1;
      waitv(0, 1);
      oc_req <= 1;
      waitv(5, 1);
      oc_req <= 0;
      waitv(0, 1);
      apb(0, `ADDR_IRQ_STAT, 0);
      chk("no trip", rd[1], 0);
      $display("test current end");
      thermistor_level <= 10'h201;
      waitv(0, 1);
      repeat (8) @(posedge clk);
      chk("ignore", {gate_enable, motor_overheat_output}, 2'h2);
      thermistor_level <= 10'h200;
      repeat (4) @(posedge clk);
      apb(1, `ADDR_CTRL, 32'h0000_0050);
      repeat (8) @(posedge clk);
      chk("at level", motor_overheat_output, 0);
      thermistor_level <= 10'h201;
      waitv(4, 1);
      chk("running", gate_enable, 1);
      apb(1, `ADDR_CTRL, 32'h0000_0030);
      waitv(0, 0);
      apb(0, `ADDR_IRQ_STAT, 0);
      chk("thm trip", rd[2], 1);
      $display("test thermistor end");
      close_out;
   end
endmodule
